// [bcse_top.sv]
// Package and top module of the bit-operation and compare-and-skip execution unit
`timescale 1ns/1ps

package bcse_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_ACC    = 8'h04;
  localparam logic [7:0] OFF_FLAGS  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  // Command word fields
  localparam int unsigned CMD_OP_LSB   = 0;
  localparam int unsigned CMD_OP_W     = 4;
  localparam int unsigned CMD_BIT_LSB  = 4;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_IMM_LSB  = 16;
  // Flag and status bit positions
  localparam int unsigned FLAG_Z  = 0;
  localparam int unsigned FLAG_C  = 1;
  localparam int unsigned FLAG_AC = 2;
  localparam int unsigned FLAG_OV = 3;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_SKIP = 1;
  // Reset values
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  typedef enum logic [3:0] {
    OP_NOP, OP_CLR_IO, OP_SET_IO, OP_TOG_IO, OP_CLR_MEM, OP_SET_MEM,
    OP_SWAPC_IO, OP_CEQ_IMM, OP_CEQ_MEM, OP_CEQ_MEM_REV, OP_CNEQ_MEM
  } bcse_op_e;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC} bcse_state_e;
  typedef enum logic [1:0] {BIT_CLEAR, BIT_FORCE, BIT_TOGGLE, BIT_LOAD} bcse_bitmode_e;
endpackage

module bcse_top #(
  parameter int unsigned IO_AW  = 6,   // IO register address width
  parameter int unsigned MEM_AW = 8    // Data memory address width
) (
  input  wire logic              clk_sys,    // System clock, 25 MHz
  input  wire logic              reset,      // Asynchronous reset, active high
  input  wire logic              psel,       // APB select
  input  wire logic              penable,    // APB enable
  input  wire logic              pwrite,     // APB direction
  input  wire logic [7:0]        paddr,      // APB byte address
  input  wire logic [31:0]       pwdata,     // APB write data
  input  wire logic [3:0]        pstrb,      // APB byte strobes
  output logic      [31:0]       prdata,     // APB read data
  output logic                   pready,     // APB ready
  output logic                   pslverr,    // APB error
  output logic      [IO_AW-1:0]  io_addr,    // IO register address
  output logic                   io_re,      // IO read strobe
  input  wire logic [7:0]        io_rdata,   // IO read data, one cycle after strobe
  input  wire logic [7:0]        io_dir,     // Direction of addressed port, 1 = output
  output logic                   io_we,      // IO write strobe
  output logic      [7:0]        io_wdata,   // IO write data
  input  wire logic [7:0]        pin_in,     // Pin levels of addressed port
  output logic      [MEM_AW-1:0] mem_addr,   // Data memory address
  output logic                   mem_re,     // Memory read strobe
  input  wire logic [7:0]        mem_rdata,  // Memory read data, one cycle after strobe
  output logic                   mem_we,     // Memory write strobe
  output logic      [7:0]        mem_wdata,  // Memory write data
  output logic                   skip_next,  // Sequencer must skip next instruction
  output logic                   busy        // An operation is in progress
);

  // The command word carries an eight bit address field
  if (IO_AW > 8 || MEM_AW > 8 || IO_AW < 1 || MEM_AW < 1) begin : g_chk
    $error("bcse_top: address widths must be 1 to 8");
  end

  bcse_pkg::bcse_state_e  state_reg;
  bcse_pkg::bcse_op_e     op_reg;
  bcse_pkg::bcse_op_e     new_op;
  bcse_pkg::bcse_bitmode_e bit_mode;
  logic [2:0]  bit_reg;
  logic [7:0]  addr_reg;
  logic [7:0]  imm_reg;
  logic [7:0]  acc_reg;
  logic [3:0]  flags_reg;
  logic        last_skip_reg;
  logic [7:0]  pin_s1_reg;
  logic [7:0]  pin_s2_reg;
  logic [31:0] prdata_reg;
  logic        io_re_reg, mem_re_reg, io_we_reg, mem_we_reg, skip_reg;
  logic [7:0]  io_wdata_reg, mem_wdata_reg;
  logic        setup_ph, access_wr, access_ph, hit_cmd, hit_acc, hit_flags, hit_stat;
  logic        op_legal, refuse, cmd_go, exec_now;
  logic        is_io_op, is_mem_op, is_cmp, is_io_wr, is_mem_wr, is_swap;
  logic [7:0]  src_byte, cmp_opnd, bit_out;
  logic        f_z, f_c, f_ac, f_ov, cmp_eq, swap_carry, imm_hit;

  // Address decode of the four registers
  assign hit_cmd   = (paddr == bcse_pkg::OFF_CMD);
  assign hit_acc   = (paddr == bcse_pkg::OFF_ACC);
  assign hit_flags = (paddr == bcse_pkg::OFF_FLAGS);
  assign hit_stat  = (paddr == bcse_pkg::OFF_STATUS);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign access_wr = access_ph && pwrite;

  // Command decode straight from the write data
  assign new_op   = bcse_pkg::bcse_op_e'(pwdata[bcse_pkg::CMD_OP_LSB +: bcse_pkg::CMD_OP_W]);
  assign op_legal = (new_op >= bcse_pkg::OP_CLR_IO) && (new_op <= bcse_pkg::OP_CNEQ_MEM);
  assign imm_hit  = (acc_reg == pwdata[bcse_pkg::CMD_IMM_LSB +: 8]);

  // Writes other than to status are refused during an operation so software never races the flags
  always_comb begin
    refuse = 1'b0;
    if (!(hit_cmd || hit_acc || hit_flags || hit_stat)) begin
      refuse = 1'b1;
    end else if (pwrite && busy && !hit_stat) begin
      refuse = 1'b1;
    end else if (pwrite && hit_cmd && !op_legal) begin
      refuse = 1'b1;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access_ph && refuse;
  assign prdata  = prdata_reg;
  assign cmd_go  = access_wr && hit_cmd && !refuse;
  assign busy    = (state_reg != bcse_pkg::ST_IDLE);

  // Read data is registered in the setup phase, ready in the access phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      if (hit_cmd) begin
        prdata_reg <= {8'h00, imm_reg, addr_reg, 1'b0, bit_reg, op_reg};
      end else if (hit_acc) begin
        prdata_reg <= {24'h00_0000, acc_reg};
      end else if (hit_flags) begin
        prdata_reg <= {28'h000_0000, flags_reg};
      end else if (hit_stat) begin
        prdata_reg <= {30'h0000_0000, last_skip_reg, busy};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Operation classes
  always_comb begin
    is_io_op  = 1'b0;
    is_mem_op = 1'b0;
    is_cmp    = 1'b0;
    is_swap   = 1'b0;
    bit_mode  = bcse_pkg::BIT_LOAD;
    case (op_reg)
      bcse_pkg::OP_CLR_IO: begin
        is_io_op = 1'b1;
        bit_mode = bcse_pkg::BIT_CLEAR;
      end
      bcse_pkg::OP_SET_IO: begin
        is_io_op = 1'b1;
        bit_mode = bcse_pkg::BIT_FORCE;
      end
      bcse_pkg::OP_TOG_IO: begin
        is_io_op = 1'b1;
        bit_mode = bcse_pkg::BIT_TOGGLE;
      end
      bcse_pkg::OP_SWAPC_IO: begin
        is_io_op = 1'b1;
        is_swap  = 1'b1;
      end
      bcse_pkg::OP_CLR_MEM: begin
        is_mem_op = 1'b1;
        bit_mode  = bcse_pkg::BIT_CLEAR;
      end
      bcse_pkg::OP_SET_MEM: begin
        is_mem_op = 1'b1;
        bit_mode  = bcse_pkg::BIT_FORCE;
      end
      bcse_pkg::OP_CEQ_IMM: begin
        is_cmp = 1'b1;
      end
      bcse_pkg::OP_CEQ_MEM, bcse_pkg::OP_CEQ_MEM_REV, bcse_pkg::OP_CNEQ_MEM: begin
        is_cmp    = 1'b1;
        is_mem_op = 1'b1;
      end
      default: begin
        is_io_op = 1'b0;
      end
    endcase
  end

  // Compares only read memory, never write it back
  assign is_io_wr  = is_io_op;
  assign is_mem_wr = is_mem_op && !is_cmp;
  assign exec_now  = (state_reg == bcse_pkg::ST_EXEC);
  assign src_byte  = is_io_op ? io_rdata : mem_rdata;
  assign cmp_opnd  = (op_reg == bcse_pkg::OP_CEQ_IMM) ? imm_reg : mem_rdata;
  assign cmp_eq    = (acc_reg == cmp_opnd);

  bcse_bit_update #(
    .W     (8),
    .IDX_W (3)
  ) u_bit (
    .byte_in  (src_byte),
    .bit_idx  (bit_reg),
    .mode     (bit_mode),
    .load_val (flags_reg[bcse_pkg::FLAG_C]),
    .byte_out (bit_out)
  );

  // Both memory operand orders use accumulator minus memory
  bcse_sub_flags u_flags (
    .minuend    (acc_reg),
    .subtrahend (cmp_opnd),
    .zero_o     (f_z),
    .carry_o    (f_c),
    .aux_o      (f_ac),
    .ovf_o      (f_ov)
  );

  // Output port offers its latch bit, input port offers the synchronised pin
  assign swap_carry = io_dir[bit_reg] ? io_rdata[bit_reg] : pin_s2_reg[bit_reg];

  // Two flops on the pins before anything reads them
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Sequence: accept, one read cycle, one execute cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= bcse_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        bcse_pkg::ST_IDLE: begin
          if (cmd_go) begin
            state_reg <= bcse_pkg::ST_READ;
          end
        end
        bcse_pkg::ST_READ: begin
          state_reg <= bcse_pkg::ST_EXEC;
        end
        default: begin
          state_reg <= bcse_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Command fields are held for the whole operation
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      op_reg   <= bcse_pkg::OP_NOP;
      bit_reg  <= 3'h0;
      addr_reg <= 8'h00;
      imm_reg  <= 8'h00;
    end else if (cmd_go) begin
      op_reg   <= new_op;
      bit_reg  <= pwdata[bcse_pkg::CMD_BIT_LSB +: 3];
      addr_reg <= pwdata[bcse_pkg::CMD_ADDR_LSB +: 8];
      imm_reg  <= pwdata[bcse_pkg::CMD_IMM_LSB +: 8];
    end
  end

  // Read strobes in the READ cycle only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      io_re_reg  <= 1'b0;
      mem_re_reg <= 1'b0;
    end else begin
      io_re_reg  <= cmd_go && (new_op inside {bcse_pkg::OP_CLR_IO, bcse_pkg::OP_SET_IO,
                    bcse_pkg::OP_TOG_IO, bcse_pkg::OP_SWAPC_IO});
      mem_re_reg <= cmd_go && (new_op inside {bcse_pkg::OP_CLR_MEM, bcse_pkg::OP_SET_MEM,
                    bcse_pkg::OP_CEQ_MEM, bcse_pkg::OP_CEQ_MEM_REV, bcse_pkg::OP_CNEQ_MEM});
    end
  end

  // Write-back strobes and data one cycle after execute
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      io_we_reg     <= 1'b0;
      mem_we_reg    <= 1'b0;
      io_wdata_reg  <= 8'h00;
      mem_wdata_reg <= 8'h00;
    end else begin
      io_we_reg  <= exec_now && is_io_wr;
      mem_we_reg <= exec_now && is_mem_wr;
      if (exec_now) begin
        io_wdata_reg  <= bit_out;
        mem_wdata_reg <= bit_out;
      end
    end
  end

  // Skip decision; equal for the equal forms, differ for the not-equal form
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      skip_reg      <= 1'b0;
      last_skip_reg <= 1'b0;
    end else begin
      skip_reg <= exec_now && is_cmp &&
                  ((op_reg == bcse_pkg::OP_CNEQ_MEM) ? !cmp_eq : cmp_eq);
      if (exec_now) begin
        last_skip_reg <= is_cmp &&
                         ((op_reg == bcse_pkg::OP_CNEQ_MEM) ? !cmp_eq : cmp_eq);
      end
    end
  end

  // Accumulator is software's alone; no operation here writes it
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_reg <= bcse_pkg::ACC_RST;
    end else if (access_wr && hit_acc && !refuse && pstrb[0]) begin
      acc_reg <= pwdata[7:0];
    end
  end

  // Flags: compares set all four, swap sets carry only, bit ops none
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_reg <= bcse_pkg::FLAGS_RST;
    end else if (exec_now && is_cmp) begin
      flags_reg[bcse_pkg::FLAG_Z]  <= f_z;
      flags_reg[bcse_pkg::FLAG_C]  <= f_c;
      flags_reg[bcse_pkg::FLAG_AC] <= f_ac;
      flags_reg[bcse_pkg::FLAG_OV] <= f_ov;
    end else if (exec_now && is_swap) begin
      flags_reg[bcse_pkg::FLAG_C] <= swap_carry;
    end else if (access_wr && hit_flags && !refuse && pstrb[0]) begin
      flags_reg <= pwdata[3:0];
    end
  end

  assign io_addr   = addr_reg[IO_AW-1:0];
  assign mem_addr  = addr_reg[MEM_AW-1:0];
  assign io_re     = io_re_reg;
  assign mem_re    = mem_re_reg;
  assign io_we     = io_we_reg;
  assign mem_we    = mem_we_reg;
  assign io_wdata  = io_wdata_reg;
  assign mem_wdata = mem_wdata_reg;
  assign skip_next = skip_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_read_then_exec;
    (state_reg == bcse_pkg::ST_READ) ##1 exec_now;
  endsequence

  sequence s_exec_op(bcse_pkg::bcse_op_e o);
    exec_now && (op_reg == o);
  endsequence

  property p_clr_io;
    s_exec_op(bcse_pkg::OP_CLR_IO) |=> io_we && !mem_we && (flags_reg == $past(flags_reg))
      && (io_wdata == ($past(io_rdata) & ~(8'h01 << $past(bit_reg))));
  endproperty
  a_clr_io: assert property (p_clr_io) else $error("clear IO bit wrong");

  property p_set_io;
    s_exec_op(bcse_pkg::OP_SET_IO) |=> io_we && (flags_reg == $past(flags_reg))
      && (io_wdata == ($past(io_rdata) | (8'h01 << $past(bit_reg))));
  endproperty
  a_set_io: assert property (p_set_io) else $error("force IO bit wrong");

  property p_tog_io;
    s_exec_op(bcse_pkg::OP_TOG_IO) |=> io_we && (flags_reg == $past(flags_reg))
      && (io_wdata == ($past(io_rdata) ^ (8'h01 << $past(bit_reg))));
  endproperty
  a_tog_io: assert property (p_tog_io) else $error("toggle IO bit wrong");

  property p_clr_mem;
    s_exec_op(bcse_pkg::OP_CLR_MEM) |=> mem_we && !io_we && (flags_reg == $past(flags_reg))
      && (mem_wdata == ($past(mem_rdata) & ~(8'h01 << $past(bit_reg))));
  endproperty
  a_clr_mem: assert property (p_clr_mem) else $error("clear memory bit wrong");

  property p_set_mem;
    s_exec_op(bcse_pkg::OP_SET_MEM) |=> mem_we && (flags_reg == $past(flags_reg))
      && (mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_reg))));
  endproperty
  a_set_mem: assert property (p_set_mem) else $error("force memory bit wrong");

  property p_swap_flags;
    s_exec_op(bcse_pkg::OP_SWAPC_IO) |=> io_we && (flags_reg[0] == $past(flags_reg[0]))
      && (flags_reg[3:2] == $past(flags_reg[3:2]));
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap hit other flags");

  property p_swap_out;
    s_exec_op(bcse_pkg::OP_SWAPC_IO) ##0 io_dir[bit_reg] |=>
      (io_wdata[$past(bit_reg)] == $past(flags_reg[bcse_pkg::FLAG_C]))
      && (flags_reg[bcse_pkg::FLAG_C] == $past(io_rdata[bit_reg]));
  endproperty
  a_swap_out: assert property (p_swap_out) else $error("swap to output bit wrong");

  property p_swap_in;
    s_exec_op(bcse_pkg::OP_SWAPC_IO) ##0 !io_dir[bit_reg] |=>
      (flags_reg[bcse_pkg::FLAG_C] == $past(pin_s2_reg[bit_reg]));
  endproperty
  a_swap_in: assert property (p_swap_in) else $error("swap from input pin wrong");

  property p_ceq_imm;
    cmd_go && (new_op == bcse_pkg::OP_CEQ_IMM) |=>
      s_read_then_exec ##1 (skip_next == $past(imm_hit, 3));
  endproperty
  a_ceq_imm: assert property (p_ceq_imm) else $error("immediate equal-skip wrong");

  property p_cmp_flags;
    exec_now && is_cmp |=> (flags_reg[0] == ($past(acc_reg) == $past(cmp_opnd)))
      && (flags_reg[1] == ($past(acc_reg) < $past(cmp_opnd)));
  endproperty
  a_cmp_flags: assert property (p_cmp_flags) else $error("compare flags wrong");

  property p_ceq_mem;
    exec_now && ((op_reg == bcse_pkg::OP_CEQ_MEM) || (op_reg == bcse_pkg::OP_CEQ_MEM_REV))
      |=> (skip_next == ($past(acc_reg) == $past(mem_rdata)));
  endproperty
  a_ceq_mem: assert property (p_ceq_mem) else $error("memory equal-skip wrong");

  property p_cneq_mem;
    s_exec_op(bcse_pkg::OP_CNEQ_MEM) |=> (skip_next == ($past(acc_reg) != $past(mem_rdata)));
  endproperty
  a_cneq_mem: assert property (p_cneq_mem) else $error("not-equal-skip wrong");

  property p_cmp_no_write;
    exec_now && is_cmp |=> !mem_we && !io_we && (acc_reg == $past(acc_reg));
  endproperty
  a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare wrote");

endmodule

// [bcse_sub_flags.sv]
// Subtract-and-compare flag unit for the compare-and-skip operations
`timescale 1ns/1ps

module bcse_sub_flags (
  input  wire logic [7:0] minuend,     // Accumulator value
  input  wire logic [7:0] subtrahend,  // Immediate or memory byte
  output logic            zero_o,      // Difference is zero
  output logic            carry_o,     // Borrow out of bit 7
  output logic            aux_o,       // Borrow out of bit 3
  output logic            ovf_o        // Signed overflow of the difference
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  // Nine and five bit differences expose the borrows without extra logic
  assign diff     = {1'b0, minuend} - {1'b0, subtrahend};
  assign low_diff = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};

  // Flags follow a plain subtraction of the second operand
  assign zero_o  = (diff[7:0] == 8'h00);
  assign carry_o = diff[8];
  assign aux_o   = low_diff[4];
  assign ovf_o   = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ diff[7]);

endmodule

// [bcse_bit_update.sv]
// Single-bit clear, force, toggle or load of one byte
`timescale 1ns/1ps

module bcse_bit_update #(
  parameter int unsigned W     = 8,
  parameter int unsigned IDX_W = $clog2(W)
) (
  input  wire logic [W-1:0]               byte_in,   // Byte as read
  input  wire logic [IDX_W-1:0]           bit_idx,   // Selected bit
  input  wire bcse_pkg::bcse_bitmode_e    mode,      // What to do with it
  input  wire logic                       load_val,  // Value for load mode
  output logic      [W-1:0]               byte_out   // Byte to write back
);

  // The index must address exactly the W bits of the byte
  if (W < 2 || IDX_W != $clog2(W)) begin : g_chk
    $error("bcse_bit_update: IDX_W must equal clog2 of W");
  end

  // Only the selected bit may change, every other bit passes through
  for (genvar i = 0; i < W; i++) begin : g_bit
    localparam logic [IDX_W-1:0] SEL = IDX_W'(i);
    assign byte_out[i] = (bit_idx != SEL)                    ? byte_in[i] :
                         (mode == bcse_pkg::BIT_CLEAR)        ? 1'b0 :
                         (mode == bcse_pkg::BIT_FORCE)        ? 1'b1 :
                         (mode == bcse_pkg::BIT_TOGGLE)       ? ~byte_in[i] :
                                                                load_val;
  end

endmodule

// [bcse_far_model.sv]
// Behavioural IO register file and data memory facing the execution unit
`timescale 1ns/1ps

module bcse_far_model (
  input  wire logic       clk_sys,    // System clock
  input  wire logic       reset,      // Asynchronous reset, active high
  input  wire logic       io_re,      // IO read strobe
  input  wire logic       io_we,      // IO write strobe
  input  wire logic [7:0] io_wdata,   // IO write data
  input  wire logic       mem_re,     // Memory read strobe
  input  wire logic       mem_we,     // Memory write strobe
  input  wire logic [7:0] mem_wdata,  // Memory write data
  input  wire logic [7:0] io_val,     // Byte the IO register holds
  input  wire logic [7:0] mem_val,    // Byte the memory cell holds
  output logic      [7:0] io_rdata,   // IO read data
  output logic      [7:0] mem_rdata,  // Memory read data
  output logic      [7:0] io_got,     // Last IO byte written
  output logic      [7:0] mem_got,    // Last memory byte written
  output int              io_n,       // Count of IO writes
  output int              mem_n       // Count of memory writes
);
  // Data holds one cycle after the strobe, then flips each cycle so late use shows
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      io_rdata  <= 8'hA5;
      mem_rdata <= 8'h5A;
    end else begin
      io_rdata  <= io_re ? io_val : ~io_rdata;
      mem_rdata <= mem_re ? mem_val : ~mem_rdata;
    end
  end

  // Write capture; counts let the bench prove that compares write nothing
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      io_got  <= 8'h00;
      mem_got <= 8'h00;
      io_n    <= 0;
      mem_n   <= 0;
    end else begin
      if (io_we) begin
        io_got <= io_wdata;
        io_n   <= io_n + 1;
      end
      if (mem_we) begin
        mem_got <= mem_wdata;
        mem_n   <= mem_n + 1;
      end
    end
  end
endmodule

// [bcse_top_tb.sv]
// Self-checking bench for the bit-operation and compare-and-skip unit
`timescale 1ns/1ps

module bcse_top_tb;
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] b;
    logic [7:0] imm, acc;
    logic [3:0] fl;
    logic [7:0] io, dir, pin, mem, ew;
    logic [3:0] ef;
    logic       es;
  } bcse_row_s;

  logic        clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, io_dir = 8'h00, pin_in = 8'h00, io_val = 8'h00, mem_val = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic [5:0]  io_addr;
  logic [7:0]  mem_addr, io_rdata, io_wdata, mem_rdata, mem_wdata, io_got, mem_got;
  logic        pready, pslverr, io_re, io_we, mem_re, mem_we, skip_next, busy, er;
  int          io_n, mem_n, n_errors = 0, n_checks = 0, n_skip = 0, i, s0, w0;
  bcse_row_s   r;
  // op, bit, imm, acc, flags in, io, dir, pin, mem, byte written, flags out, skip
  bcse_row_s   rows [15] = '{
    '{4'h1,3'h5,8'h00,8'h00,4'hF,8'hFF,8'h00,8'h00,8'h00,8'hDF,4'hF,1'h0},
    '{4'h2,3'h0,8'h00,8'h00,4'hA,8'h00,8'h00,8'h00,8'h00,8'h01,4'hA,1'h0},
    '{4'h3,3'h7,8'h00,8'h00,4'h5,8'hC3,8'h00,8'h00,8'h00,8'h43,4'h5,1'h0},
    '{4'h4,3'h3,8'h00,8'h00,4'hF,8'h00,8'h00,8'h00,8'hFF,8'hF7,4'hF,1'h0},
    '{4'h5,3'h6,8'h00,8'h00,4'h0,8'h00,8'h00,8'h00,8'h81,8'hC1,4'h0,1'h0},
    '{4'h6,3'h0,8'h00,8'h00,4'hD,8'h01,8'h01,8'h00,8'h00,8'h00,4'hF,1'h0},
    '{4'h6,3'h2,8'h00,8'h00,4'h2,8'h00,8'hFB,8'hFB,8'h00,8'h04,4'h0,1'h0},
    '{4'h6,3'h2,8'h00,8'h00,4'h0,8'hFF,8'h00,8'h04,8'h00,8'hFB,4'h2,1'h0},
    '{4'h7,3'h0,8'h38,8'h38,4'h0,8'h00,8'h00,8'h00,8'h00,8'h00,4'h1,1'h1},
    '{4'h7,3'h0,8'h42,8'h38,4'h0,8'h00,8'h00,8'h00,8'h00,8'h00,4'h2,1'h0},
    '{4'h8,3'h0,8'h00,8'h38,4'h0,8'h00,8'h00,8'h00,8'h6A,8'h00,4'h6,1'h0},
    '{4'h9,3'h0,8'h00,8'h55,4'h0,8'h00,8'h00,8'h00,8'h55,8'h00,4'h1,1'h1},
    '{4'hA,3'h0,8'h00,8'h80,4'h0,8'h00,8'h00,8'h00,8'h01,8'h00,4'hC,1'h1},
    '{4'hA,3'h0,8'h00,8'h24,4'hF,8'h00,8'h00,8'h00,8'h24,8'h00,4'h1,1'h0},
    '{4'h8,3'h0,8'h00,8'h38,4'hF,8'h00,8'h00,8'h00,8'h38,8'h00,4'h1,1'h1}};

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  // Skip pulses are counted so a stuck-high or missing pulse shows
  always @(posedge clk_sys) if (skip_next === 1'b1) n_skip <= n_skip + 1;

  bcse_top u_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .io_addr(io_addr), .io_re(io_re),
    .io_rdata(io_rdata), .io_dir(io_dir), .io_we(io_we), .io_wdata(io_wdata),
    .pin_in(pin_in), .mem_addr(mem_addr), .mem_re(mem_re), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .skip_next(skip_next), .busy(busy));

  bcse_far_model u_far (.clk_sys(clk_sys), .reset(reset), .io_re(io_re), .io_we(io_we),
    .io_wdata(io_wdata), .mem_re(mem_re), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .io_val(io_val), .mem_val(mem_val), .io_rdata(io_rdata), .mem_rdata(mem_rdata),
    .io_got(io_got), .mem_got(mem_got), .io_n(io_n), .mem_n(mem_n));

  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; psel stays up so another setup may follow at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
  endtask

  // Release the bus and wait until the running operation has finished
  task automatic wait_done();
    psel <= 1'b0;
    @(negedge clk_sys);
    while (busy !== 1'b0) @(negedge clk_sys);
    @(posedge clk_sys);
  endtask

  initial begin
    #200000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (i = 0; i < 15; i++) begin
      r = rows[i];
      io_val <= r.io;
      mem_val <= r.mem;
      io_dir <= r.dir;
      pin_in <= r.pin;
      s0 = n_skip;
      w0 = io_n + mem_n;
      apb(1'b1, bcse_pkg::OFF_ACC, {24'h0, r.acc});
      apb(1'b1, bcse_pkg::OFF_FLAGS, {28'h0, r.fl});
      apb(1'b1, bcse_pkg::OFF_CMD, {8'h00, r.imm, 8'h10, 1'b0, r.b, r.op});
      wait_done();
      apb(1'b0, bcse_pkg::OFF_FLAGS, 32'h0);
      chk(rd, {28'h0, r.ef});
      apb(1'b0, bcse_pkg::OFF_ACC, 32'h0);
      chk(rd, {24'h0, r.acc});
      apb(1'b0, bcse_pkg::OFF_STATUS, 32'h0);
      psel <= 1'b0;
      chk(rd, {30'h0, r.es, 1'b0});
      chk(n_skip - s0, {31'h0, r.es});
      chk(io_n + mem_n - w0, {31'h0, r.op < 4'h7});
      if (r.op < 4'h7) chk({24'h0, (r.op inside {4'h4, 4'h5}) ? mem_got : io_got},
        {24'h0, r.ew});
      chk({26'h0, io_addr}, 32'h00000010);
      chk({24'h0, mem_addr}, 32'h00000010);
      @(posedge clk_sys);
    end
    // Refused op codes and an unmapped address
    apb(1'b1, bcse_pkg::OFF_CMD, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, bcse_pkg::OFF_CMD, 32'h0000100B);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // A write with lane 0 disabled leaves the accumulator alone
    pstrb <= 4'hE;
    apb(1'b1, bcse_pkg::OFF_ACC, 32'h00000055);
    pstrb <= 4'hF;
    // Accumulator write right behind a command lands while busy and is refused
    apb(1'b1, bcse_pkg::OFF_CMD, 32'h00001002);
    apb(1'b1, bcse_pkg::OFF_ACC, 32'h00000077);
    chk({31'h0, er}, 32'h1);
    wait_done();
    apb(1'b0, bcse_pkg::OFF_ACC, 32'h0);
    chk(rd, 32'h00000038);
    // Second reset in mid-run clears accumulator and flags
    psel <= 1'b0;
    reset <= 1'b1;
    @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, bcse_pkg::OFF_ACC, 32'h0);
    chk(rd, {24'h0, bcse_pkg::ACC_RST});
    apb(1'b0, bcse_pkg::OFF_FLAGS, 32'h0);
    chk(rd, {28'h0, bcse_pkg::FLAGS_RST});
    psel <= 1'b0;
    report_and_stop();
  end
endmodule
